// file: udmae_burst_engine.sv
// host side ultra dma burst engine for one ata channel
`timescale 1ns/100ps
`default_nettype none

// How it works
// - synchronous bursts only for drives whose enable bit at 48h is set
// - host always drives the stop line, to request or acknowledge a stop
// - reads: host drives ready on its strobe line, drive strobes on its line
// - writes: host strobes on its strobe line, drive signals ready on its line
// - drive requests, host grants; chip selects inactive, address low meanwhile
// - writes: drop stop, wait for drive ready, then first word and strobe
// - reads: release data bus, drop stop, assert ready; drive sends data
// - receiver takes one word on each rising and falling strobe edge
// - transmitter pauses by holding strobe; receiver pauses by dropping ready
// - host pauses on buffer full or empty and while fetching a descriptor
// - host stop: host asserts stop, drive acknowledges by dropping request
// - drive stop: drive drops request, host acknowledges by asserting stop
// - strobe parked high, host drives crc, then releases the grant
// - host ends bursts for other channel, pio access, or final data
// - crc over every strobed word, restarted for each burst
// - fast timing selected per drive by bits 3:0 at 54h
// - fast bit runs that drive's transfers on the higher-rate timing
// - each drive has own base clock, cycle count and ready-to-stop count
// - cycle count sets least base clocks per host strobe phase
// - read stop: wait ready-to-stop base clocks after dropping ready
// - mode 5 uses three base clocks per phase; two bytes per edge
// - exhausted descriptor: request next one and reload current byte count
module udmae_burst_engine
    import udmae_pkg::*;
(
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire udmae_cfg_req_t             cfg_i,
    output logic [31:0]                     cfg_rdata_o,
    input  wire udmae_timing_t [3:0]        drive_timing_i,
    input  wire logic [1:0]                 drive_sel_i,
    input  wire logic                       dir_write_i,
    input  wire logic                       burst_go_i,
    input  wire logic                       other_channel_req_i,
    input  wire logic                       pio_req_i,
    input  wire logic                       desc_load_i,
    input  wire logic [16:0]                desc_count_i,
    input  wire logic                       desc_final_i,
    output logic                            desc_fetch_req_o,
    input  wire logic                       tx_valid_i,
    input  wire logic [15:0]                tx_data_i,
    output logic                            tx_ready_o,
    output logic                            rx_valid_o,
    output logic [15:0]                     rx_data_o,
    input  wire logic                       rx_room_i,
    output logic                            legacy_dma_o,
    output logic                            burst_active_o,
    input  wire logic                       dmarq_i,
    output logic                            dma_grant_line_n_o,
    output logic                            primary_stop_line_o,
    output logic                            primary_host_strobe_ready_line_o,
    input  wire logic                       primary_device_strobe_ready_line_i,
    output logic [1:0]                      cs_n_o,
    output logic [2:0]                      da_o,
    input  wire logic [15:0]                dd_i,
    output logic [15:0]                     dd_o,
    output logic                            dd_oe_n_o
);

    typedef enum logic [3:0] {
        UDMAE_IDLE, UDMAE_GRANT, UDMAE_WR_DATA, UDMAE_RD_DATA, UDMAE_RD_WAIT_RP,
        UDMAE_STOP_REQ, UDMAE_PARK, UDMAE_CRC_OUT, UDMAE_CRC_HOLD
    } udmae_state_t;

    udmae_state_t  state;
    logic [7:0]    sync_dma_drive_enable;
    logic [31:0]   ide_drive_clock_config;
    logic [1:0]    dmarq_sync;
    logic [2:0]    dev_line_sync;
    logic [15:0]   dd_s1;
    logic [15:0]   dd_s2;
    logic [3:0]    base_div;
    logic          base_tick;
    logic [3:0]    phase_cnt;
    logic [16:0]   cur_count;
    logic          fetching;
    logic          word_loaded;
    logic          host_strobe;
    logic          host_ready_n;
    logic          rd_edge;
    logic          crc_clear;
    logic          crc_update;
    logic [15:0]   crc_value;
    logic [15:0]   crc_word;
    logic          fast_sel;
    logic [3:0]    ct_eff;
    logic [3:0]    rp_eff;
    logic          phase_done;
    logic          host_stop_want;
    logic          count_out;
    logic          dmarq_s;
    logic          dev_line_s;

    // config port: synchronous enable at 48h, drive clock config at 54h
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_dma_drive_enable  <= UDMAE_SYNC_EN_RST;
            ide_drive_clock_config <= UDMAE_CLK_CFG_RST;
        end else if (cfg_i.wr) begin
            if (cfg_i.addr == UDMAE_SYNC_EN_OFS) begin
                sync_dma_drive_enable <= cfg_i.wdata[7:0];
            end
            if (cfg_i.addr == UDMAE_CLK_CFG_OFS) begin
                ide_drive_clock_config <= cfg_i.wdata;
            end
        end
    end

    // registered read data, unmapped offsets read zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= 32'h0000_0000;
        end else if (cfg_i.rd) begin
            unique case (cfg_i.addr)
                UDMAE_SYNC_EN_OFS: cfg_rdata_o <= {24'h000000, sync_dma_drive_enable};
                UDMAE_CLK_CFG_OFS: cfg_rdata_o <= ide_drive_clock_config;
                default:           cfg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // two-flop synchronisers for cable inputs
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dmarq_sync    <= 2'h0;
            dev_line_sync <= 3'h7;
            dd_s1         <= 16'h0000;
            dd_s2         <= 16'h0000;
        end else begin
            dmarq_sync    <= {dmarq_sync[0], dmarq_i};
            dev_line_sync <= {dev_line_sync[1:0], primary_device_strobe_ready_line_i};
            dd_s1         <= dd_i;
            dd_s2         <= dd_s1;
        end
    end

    assign dmarq_s    = dmarq_sync[1];
    assign dev_line_s = dev_line_sync[1];
    // both strobe edges carry a word
    // edge on synchronised drive strobe
    assign rd_edge    = dev_line_sync[1] ^ dev_line_sync[2];

    // fast bit of the selected drive
    assign fast_sel = ide_drive_clock_config[UDMAE_DRV_LSB + 32'(drive_sel_i)];
    // mode 5 default of three base clocks when a fast drive has no count set, one for a slow drive
    assign ct_eff = (drive_timing_i[drive_sel_i].strobe_cycle_count == 4'h0)
                    ? (fast_sel ? UDMAE_MODE5_CT : 4'h1)
                    : drive_timing_i[drive_sel_i].strobe_cycle_count;
    assign rp_eff = drive_timing_i[drive_sel_i].ready_to_stop_count;
    // legacy signalling when the drive's enable bit is clear
    assign legacy_dma_o = !sync_dma_drive_enable[UDMAE_DRV_LSB + 32'(drive_sel_i)];

    // base clock enable divider
    // fast drives use the higher-rate base clock
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            base_div <= 4'h0;
        end else if (base_tick) begin
            base_div <= 4'h0;
        end else begin
            base_div <= base_div + 4'h1;
        end
    end
    assign base_tick = (base_div + 4'h1) >= (fast_sel ? UDMAE_BASE_DIV_FAST : UDMAE_BASE_DIV_SLOW);

    // phase ends after the cycle count in base clocks
    assign phase_done = (phase_cnt >= ct_eff);
    assign count_out  = (cur_count == 17'h00000);
    // other channel, pio access, final data or engine halted
    assign host_stop_want = other_channel_req_i || pio_req_i || !burst_go_i
                            || (count_out && desc_final_i);

    // write handshake: take a word when none is pending and the drive is ready
    // no word taken while buffer empty or descriptor pending
    assign tx_ready_o = (state == UDMAE_WR_DATA) && !word_loaded && !count_out
                        && !host_stop_want && !dev_line_s && dmarq_s;

    // burst sequencer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= UDMAE_IDLE;
        end else begin
            unique case (state)
                UDMAE_IDLE: begin
                    // grant a pending request for an enabled drive
                    if (dmarq_s && burst_go_i && !legacy_dma_o && !count_out
                        && !other_channel_req_i && !pio_req_i) begin
                        state <= UDMAE_GRANT;
                    end
                end
                UDMAE_GRANT: begin
                    if (phase_done) begin
                        state <= dir_write_i ? UDMAE_WR_DATA : UDMAE_RD_DATA;
                    end
                end
                UDMAE_WR_DATA: begin
                    if (!dmarq_s) begin
                        state <= UDMAE_PARK;
                    end else if (host_stop_want && !word_loaded) begin
                        state <= UDMAE_STOP_REQ;
                    end
                end
                UDMAE_RD_DATA: begin
                    if (!dmarq_s) begin
                        state <= UDMAE_PARK;
                    end else if (host_stop_want) begin
                        state <= UDMAE_RD_WAIT_RP;
                    end
                end
                UDMAE_RD_WAIT_RP: begin
                    if (!dmarq_s) begin
                        state <= UDMAE_PARK;
                    end else if (phase_cnt >= rp_eff) begin
                        state <= UDMAE_STOP_REQ;
                    end
                end
                UDMAE_STOP_REQ: begin
                    if (!dmarq_s) begin
                        state <= UDMAE_PARK;
                    end
                end
                UDMAE_PARK: begin
                    if (dir_write_i ? (host_strobe && phase_done) : dev_line_s) begin
                        state <= UDMAE_CRC_OUT;
                    end
                end
                UDMAE_CRC_OUT: begin
                    if (phase_done) begin
                        state <= UDMAE_CRC_HOLD;
                    end
                end
                UDMAE_CRC_HOLD: begin
                    state <= UDMAE_IDLE;
                end
            endcase
        end
    end

    // phase counter in base clocks, restarted at each state change except into crc hold, and at strobe flip
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_cnt <= 4'h0;
        end else if ((state == UDMAE_IDLE) || (state == UDMAE_RD_DATA)
                     || (tx_ready_o && tx_valid_i) || crc_update_wr()
                     || (state == UDMAE_STOP_REQ) || (state == UDMAE_PARK && phase_done)
                     || (state == UDMAE_PARK && !dir_write_i)
                     || (state == UDMAE_GRANT && phase_done)
                     || (state == UDMAE_WR_DATA && (!dmarq_s || (host_stop_want && !word_loaded)))) begin
            phase_cnt <= 4'h0;
        end else if (base_tick && (phase_cnt != 4'hf)) begin
            phase_cnt <= phase_cnt + 4'h1;
        end
    end

    // host strobe flips once a loaded word has stood for the cycle count
    function automatic logic crc_update_wr();
        return (state == UDMAE_WR_DATA) && word_loaded && phase_done && !dev_line_s;
    endfunction

    // host write strobe and word pending flag
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_strobe <= 1'b1;
            word_loaded <= 1'b0;
        end else if (state == UDMAE_IDLE) begin
            host_strobe <= 1'b1;
            word_loaded <= 1'b0;
        // first word only after drive ready
        end else if (tx_ready_o && tx_valid_i) begin
            word_loaded <= 1'b1;
        // strobe held while drive not ready or no word
        end else if (crc_update_wr()) begin
            host_strobe <= !host_strobe;
            word_loaded <= 1'b0;
        end else if (state == UDMAE_PARK && dir_write_i && !host_strobe && phase_done) begin
            host_strobe <= 1'b1;
        end
    end

    // host read ready, active low
    // ready asserted on entry to the read data phase
    // ready dropped while receive buffer full or count exhausted
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_ready_n <= 1'b1;
        end else begin
            host_ready_n <= !((state == UDMAE_RD_DATA) && rx_room_i && !count_out && !host_stop_want);
        end
    end

    // data bus: write words and crc driven, released for reads
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dd_o      <= 16'h0000;
            dd_oe_n_o <= 1'b1;
        end else if (tx_ready_o && tx_valid_i) begin
            dd_o      <= tx_data_i;
            dd_oe_n_o <= 1'b0;
        // crc placed on the bus before the grant is released
        end else if (state == UDMAE_PARK && (dir_write_i ? (host_strobe && phase_done) : dev_line_s)) begin
            dd_o      <= crc_value;
            dd_oe_n_o <= 1'b0;
        end else if (state == UDMAE_IDLE || state == UDMAE_RD_DATA) begin
            dd_oe_n_o <= 1'b1;
        end
    end

    // received words
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o  <= 16'h0000;
        end else begin
            rx_valid_o <= !dir_write_i && rd_edge
                          && ((state == UDMAE_RD_DATA) || (state == UDMAE_RD_WAIT_RP));
            rx_data_o  <= dd_s2;
        end
    end

    // current byte count and descriptor fetch request
    // reload on descriptor arrival, request when exhausted
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_count        <= 17'h00000;
            fetching         <= 1'b0;
            desc_fetch_req_o <= 1'b0;
        end else begin
            desc_fetch_req_o <= 1'b0;
            if (desc_load_i) begin
                cur_count <= desc_count_i;
                fetching  <= 1'b0;
            end else begin
                if (crc_update && !count_out) begin
                    cur_count <= cur_count - UDMAE_BYTES_PER_EDGE;
                end
                if (count_out && !desc_final_i && !fetching && burst_go_i) begin
                    fetching         <= 1'b1;
                    desc_fetch_req_o <= 1'b1;
                end
            end
        end
    end

    // crc restarted on grant, updated on every strobed word
    assign crc_clear  = (state == UDMAE_IDLE);
    assign crc_update = crc_update_wr() || (rx_valid_o == 1'b0 && !dir_write_i && rd_edge
                        && ((state == UDMAE_RD_DATA) || (state == UDMAE_RD_WAIT_RP)))
                        || (rx_valid_o && !dir_write_i && rd_edge
                        && ((state == UDMAE_RD_DATA) || (state == UDMAE_RD_WAIT_RP)));
    assign crc_word   = dir_write_i ? dd_o : dd_s2;

    udmae_crc16 u_crc (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .clear_i  (crc_clear),
        .update_i (crc_update),
        .data_i   (crc_word),
        .crc_o    (crc_value)
    );

    // cable outputs
    // grant held from grant through crc hold; address and selects idle
    assign dma_grant_line_n_o = (state == UDMAE_IDLE);
    assign cs_n_o             = 2'h3;
    assign da_o               = 3'h0;
    assign burst_active_o     = (state != UDMAE_IDLE);
    assign primary_stop_line_o = !((state == UDMAE_WR_DATA) || (state == UDMAE_RD_DATA)
                                   || (state == UDMAE_RD_WAIT_RP));
    // read ready, write strobe on the host line
    assign primary_host_strobe_ready_line_o = dir_write_i ? host_strobe : host_ready_n;

endmodule : udmae_burst_engine
`default_nettype wire

// file: udmae_pkg.sv
// shared constants and types for the ultra dma host burst engine
package udmae_pkg;

    // configuration port offsets
    localparam logic [7:0]  UDMAE_SYNC_EN_OFS   = 8'h48;
    localparam logic [7:0]  UDMAE_CLK_CFG_OFS   = 8'h54;
    // reset values of the configuration registers
    localparam logic [7:0]  UDMAE_SYNC_EN_RST   = 8'h00;
    localparam logic [31:0] UDMAE_CLK_CFG_RST   = 32'h0000_0000;
    // field positions: drive enable bits 3:0, fast timing bits 3:0
    localparam int          UDMAE_DRV_LSB       = 0;
    localparam int          UDMAE_DRIVES        = 4;
    // base clock dividers of the system clock, slow and fast timing sets
    localparam logic [3:0]  UDMAE_BASE_DIV_SLOW = 4'h2;
    localparam logic [3:0]  UDMAE_BASE_DIV_FAST = 4'h1;
    // mode 5 strobe cycle count, used when a fast drive has no count set
    localparam logic [3:0]  UDMAE_MODE5_CT      = 4'h3;
    // two bytes move on every strobe edge
    localparam logic [16:0] UDMAE_BYTES_PER_EDGE = 17'h00002;
    // crc-16 generator and seed
    localparam logic [15:0] UDMAE_CRC_POLY      = 16'h1021;
    localparam logic [15:0] UDMAE_CRC_SEED      = 16'h4aba;

    // per-drive timing counts, in base clocks
    typedef struct packed {
        logic [3:0] strobe_cycle_count;
        logic [3:0] ready_to_stop_count;
    } udmae_timing_t;

    // configuration access from the host bridge
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } udmae_cfg_req_t;

endpackage : udmae_pkg

// file: udmae_crc16.sv
// crc-16 accumulator over 16-bit words
`timescale 1ns/100ps
`default_nettype none

module udmae_crc16
    import udmae_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        clear_i,
    input  wire logic        update_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] crc_o
);

    logic [15:0] next_crc;

    // bit-serial fold of one word, msb first
    always_comb begin
        logic fb;
        fb = 1'b0;
        next_crc = crc_o;
        for (int i = 15; i >= 0; i--) begin
            fb = next_crc[15] ^ data_i[i];
            next_crc = {next_crc[14:0], 1'b0} ^ (fb ? UDMAE_CRC_POLY : 16'h0000);
        end
    end

    // seed on clear, fold on update
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crc_o <= UDMAE_CRC_SEED;
        end else if (clear_i) begin
            crc_o <= UDMAE_CRC_SEED;
        end else if (update_i) begin
            crc_o <= next_crc;
        end
    end

endmodule : udmae_crc16
`default_nettype wire

// file: udmae_sva.sv
// pin level checker for the burst engine
`timescale 1ns/100ps
`default_nettype none
module udmae_sva (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic       dir_write_i,
    input wire logic       dmarq_i,
    input wire logic       legacy_dma_o,
    input wire logic       dma_grant_line_n_o,
    input wire logic       primary_stop_line_o,
    input wire logic       primary_host_strobe_ready_line_o,
    input wire logic       primary_device_strobe_ready_line_i,
    input wire logic       tx_ready_o,
    input wire logic [1:0] cs_n_o,
    input wire logic [2:0] da_o,
    input wire logic       dd_oe_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // write data phase while the drive holds off
    sequence s_wr_busy;
        dir_write_i && !dma_grant_line_n_o && !primary_stop_line_o && primary_device_strobe_ready_line_i;
    endsequence
    a_no_legacy_grant: assert property (legacy_dma_o |-> dma_grant_line_n_o)
        else $error("grant on a legacy drive");
    a_selects_idle: assert property (!dma_grant_line_n_o |-> cs_n_o == 2'b11 && da_o == 3'b000)
        else $error("selects active during burst");
    a_stop_when_idle: assert property (dma_grant_line_n_o |-> primary_stop_line_o)
        else $error("stop low without grant");
    a_grant_on_req: assert property ($fell(dma_grant_line_n_o) |-> $past(dmarq_i, 2))
        else $error("grant without request");
    a_read_bus_free: assert property (!dir_write_i && !dma_grant_line_n_o && !primary_stop_line_o |-> dd_oe_n_o)
        else $error("host drives data in read");
    a_write_waits: assert property (s_wr_busy [*4] |-> !tx_ready_o)
        else $error("word taken while drive not ready");
    a_stop_ack: assert property (!dma_grant_line_n_o && $fell(dmarq_i) |-> ##[1:40] primary_stop_line_o)
        else $error("drive stop not acknowledged");
    a_strobe_parked: assert property ($rose(dma_grant_line_n_o) |-> $past(primary_host_strobe_ready_line_o))
        else $error("strobe not parked high");
    a_crc_driven: assert property ($rose(dma_grant_line_n_o) |-> $past(!dd_oe_n_o))
        else $error("crc not on bus at grant release");
endmodule : udmae_sva
bind udmae_burst_engine udmae_sva i_udmae_sva (.clock_i, .rst_n_i, .dir_write_i, .dmarq_i, .legacy_dma_o,
    .dma_grant_line_n_o, .primary_stop_line_o, .primary_host_strobe_ready_line_o,
    .primary_device_strobe_ready_line_i, .tx_ready_o, .cs_n_o, .da_o, .dd_oe_n_o);
`default_nettype wire

// file: udmae_drive_model.sv
// behavioural disk drive facing the burst engine
`timescale 1ns/100ps
`default_nettype none
module udmae_drive_model (
    input  wire logic        req_i,
    input  wire logic [7:0]  nw_i,
    input  wire logic        dir_write_i,
    input  wire logic        grant_n_i,
    input  wire logic        stop_i,
    input  wire logic        host_line_i,
    input  wire logic [15:0] dd_i,
    output logic             dmarq_o,
    output logic             dev_line_o,
    output logic [15:0]      dd_o,
    output logic [15:0]      run_crc_o,
    output logic [15:0]      got_crc_o,
    output logic [15:0]      last_o,
    output logic [7:0]       n_o
);
    function automatic logic [15:0] udmae_crc(input logic [15:0] c, input logic [15:0] d);
        for (int b = 15; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction : udmae_crc
    initial begin
        dmarq_o = 1'b0;
        dev_line_o = 1'b1;
        dd_o = 16'h0000;
    end
    // request follows the bench while idle
    always @(req_i) if (grant_n_i) dmarq_o = req_i;
    always @(host_line_i) if (!grant_n_i && dir_write_i && !stop_i) begin
        run_crc_o = udmae_crc(run_crc_o, dd_i);
        last_o = dd_i;
        n_o = n_o + 8'h01;
    end
    always @(posedge grant_n_i) got_crc_o = dd_i;
    always @(negedge grant_n_i) begin
        run_crc_o = 16'h4aba;
        n_o = 8'h00;
        wait (!stop_i) #10;
        if (dir_write_i) begin
            dd_o = ~dd_o;
            #240 dev_line_o = 1'b0;
            wait (stop_i);
            #50 dmarq_o = 1'b0;
            dev_line_o = 1'b1;
        end else begin
            while (n_o < nw_i && !stop_i) begin
                if (!host_line_i) begin
                    dd_o = 16'hc3a0 ^ {8'h00, n_o};
                    run_crc_o = udmae_crc(run_crc_o, dd_o);
                    #20 dev_line_o = ~dev_line_o;
                    n_o = n_o + 8'h01;
                    #140;
                end else #40;
            end
            dmarq_o = 1'b0;
            wait (stop_i);
            #50 dev_line_o = 1'b1;
            dd_o = ~dd_o;
        end
    end
endmodule : udmae_drive_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the burst engine
`timescale 1ns/100ps
`default_nettype none
module testbench
    import udmae_pkg::*;
;
    logic clock_i = 1'b0, rst_n_i = 1'b0, dir = 1'b0, go = 1'b0, other = 1'b0, pio = 1'b0, load = 1'b0;
    logic room = 1'b1, fin = 1'b1, tx_valid = 1'b1, req = 1'b0;
    udmae_cfg_req_t      cfg = '0;
    udmae_timing_t [3:0] timing = 32'h2202_2222;
    logic [1:0]  sel = 2'h0;
    logic [16:0] count = 17'h00000;
    logic [15:0] tx_data = 16'h5a00;
    logic [7:0]  nw = 8'h00, k = 8'h00;
    int          failures = 0, n_checks = 0;
    wire logic [31:0] cfg_rdata;
    wire logic tx_ready, rx_valid, legacy, grant_n, stop, host_line, dev_line, dmarq, dd_oe_n;
    wire logic [15:0] rx_data, dd_o, drv_dd, d_run, d_got, d_last;
    wire logic [7:0]  d_n;
    // data wire level, drive or host per enable
    wire logic [15:0] dd_bus = dd_oe_n ? drv_dd : dd_o;
    udmae_burst_engine i_udmae_burst_engine (.clock_i, .rst_n_i, .cfg_i(cfg), .cfg_rdata_o(cfg_rdata),
        .drive_timing_i(timing), .drive_sel_i(sel), .dir_write_i(dir), .burst_go_i(go), .other_channel_req_i(other),
        .pio_req_i(pio), .desc_load_i(load), .desc_count_i(count), .desc_final_i(fin), .desc_fetch_req_o(),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_room_i(room), .legacy_dma_o(legacy), .burst_active_o(), .dmarq_i(dmarq), .dma_grant_line_n_o(grant_n),
        .primary_stop_line_o(stop), .primary_host_strobe_ready_line_o(host_line),
        .primary_device_strobe_ready_line_i(dev_line), .cs_n_o(), .da_o(), .dd_i(dd_bus), .dd_o(dd_o),
        .dd_oe_n_o(dd_oe_n));
    udmae_drive_model i_udmae_drive_model (.req_i(req), .nw_i(nw), .dir_write_i(dir), .grant_n_i(grant_n),
        .stop_i(stop), .host_line_i(host_line), .dd_i(dd_bus), .dmarq_o(dmarq), .dev_line_o(dev_line),
        .dd_o(drv_dd), .run_crc_o(d_run), .got_crc_o(d_got), .last_o(d_last), .n_o(d_n));
    initial forever #20 clock_i = ~clock_i;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // read words arrive in order; write words advance when taken
    always @(posedge clock_i) if (rx_valid) begin
        chk(rx_data, 16'hc3a0 ^ {8'h00, k});
        k <= k + 8'h01;
    end
    always @(posedge clock_i) if (tx_ready && tx_valid) tx_data <= tx_data + 16'h0001;
    task cfg_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        cfg <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock_i);
        cfg <= '0;
        #1 if (!w) chk(cfg_rdata, d);
    endtask : cfg_acc
    task burst(input logic w, input logic [1:0] s, input logic [16:0] c, input logic [7:0] n, input int stop_at);
        int t;
        @(posedge clock_i);
        {dir, sel, count, nw, k, load, tx_data} <= {w, s, c, n, 8'h00, 1'b1, 16'h5a00};
        @(posedge clock_i);
        {load, go, req} <= 3'b011;
        for (t = 0; t < 100 && grant_n !== 1'b0; t++) @(posedge clock_i);
        chk(grant_n, s == 2'h1);
        repeat (stop_at) @(posedge clock_i);
        pio <= (stop_at > 0);
        for (t = 0; t < 3000 && grant_n !== 1'b1; t++) @(posedge clock_i);
        {go, req, pio} <= 3'b000;
        repeat (6) @(posedge clock_i);
    endtask : burst
    task t_regs;
        cfg_acc(1'b0, 8'h48, 32'h0);
        cfg_acc(1'b0, 8'h54, 32'h0);
        cfg_acc(1'b1, 8'h48, 32'habcd_ff05);
        cfg_acc(1'b1, 8'h54, 32'h0000_0004);
        cfg_acc(1'b1, 8'h50, 32'hffff_ffff);
        cfg_acc(1'b0, 8'h48, 32'h0000_0005);
        cfg_acc(1'b0, 8'h54, 32'h0000_0004);
        cfg_acc(1'b0, 8'h50, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task t_legacy;
        burst(1'b0, 2'h1, 17'h00008, 8'h04, 0);
        chk(legacy, 1'b1);
        $display("test legacy done");
    endtask : t_legacy
    task t_write;
        burst(1'b1, 2'h2, 17'h00008, 8'h00, 0);
        chk(d_n, 8'h04);
        chk(d_last, 16'h5a03);
        chk(d_got, d_run);
        $display("test write done");
    endtask : t_write
    task t_read;
        burst(1'b0, 2'h0, 17'h00020, 8'h04, 0);
        chk(k, 8'h04);
        chk(d_got, d_run);
        $display("test read done");
    endtask : t_read
    task t_pio_stop;
        burst(1'b0, 2'h0, 17'h00100, 8'h64, 20);
        chk(k, d_n);
        chk(d_n < 8'h64, 1'b1);
        chk(d_got, d_run);
        $display("test pio stop done");
    endtask : t_pio_stop
    task finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_legacy;
        t_write;
        t_read;
        t_pio_stop;
        finish_test;
    end
    // watchdog far past the expected run
    initial begin
        #2000000;
        failures++;
        finish_test;
    end
endmodule : testbench
`default_nettype wire
